// File: inc/scb_pkg.sv
package scb_pkg;

    // Address choices and strap mapping
    localparam int         SCB_NUM_ADDRESSES     = 16;
    localparam logic [6:0] SCB_STRAP_BASE_ADDR   = 7'h0C;

    // Register at offset zero and its fields
    localparam logic [7:0] SCB_TARGET_ADDR_OFFSET = 8'h00;
    localparam logic [7:0] SCB_TARGET_ADDR_RESET  = 8'h00;
    localparam int         SCB_SOURCE_SEL_BIT     = 0;
    localparam int         SCB_ADDR_MSB           = 7;
    localparam int         SCB_ADDR_LSB           = 1;

    // Bits per byte on the bus
    localparam logic [3:0] SCB_BYTE_BITS = 4'h8;

    // Register file depth
    localparam int SCB_REG_DEPTH = 256;

    typedef enum logic [6:0] {
        SCB_IDLE  = 7'h01,
        SCB_ADDR  = 7'h02,
        SCB_AACK  = 7'h04,
        SCB_WDATA = 7'h08,
        SCB_WACK  = 7'h10,
        SCB_RDATA = 7'h20,
        SCB_RACK  = 7'h40
    } scb_state_type;

    // Open-drain pin drive pair
    typedef struct packed {
        logic out;
        logic oe;
    } scb_pin_drive_type;

    // Link-domain state
    typedef struct packed {
        logic              rst_s1;
        logic              rst_s2;
        logic              scl_s1;
        logic              scl_s2;
        logic              scl_prev;
        logic              sda_s1;
        logic              sda_s2;
        logic              sda_prev;
        logic [3:0]        strap_s1;
        logic [3:0]        strap_s2;
        scb_state_type     state;
        logic [3:0]        cnt;
        logic [7:0]        shift;
        logic              rw;
        logic              first;
        logic              mnack;
        logic [7:0]        offset;
        logic [7:0]        target_reg;
        logic              wr_en;
        logic [7:0]        wr_data;
        logic [6:0]        own_addr;
        logic              ovr;
        logic              addr_tgl;
        scb_pin_drive_type sda_drv;
        scb_pin_drive_type scl_drv;
    } scb_link_state_type;

    // System-clock domain state
    typedef struct packed {
        logic       tgl_s1;
        logic       tgl_s2;
        logic       tgl_prev;
        logic [6:0] active_addr;
        logic       override;
    } scb_sys_state_type;

endpackage : scb_pkg

// File: tb/scb_host_model.sv
`timescale 1ns/1ps

module scb_host_model (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl_oe,
    output logic      sda_oe
);
    localparam int HALF = 16;

    // Both lines released from time zero
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // One bus phase, well over four link clocks
    task automatic pause();
        repeat (HALF) @(posedge clk);
    endtask : pause

    // Start or repeated start, from either clock level
    task automatic start();
        sda_oe <= 1'b0;
        pause();
        scl_oe <= 1'b0;
        pause();
        sda_oe <= 1'b1;
        pause();
        scl_oe <= 1'b1;
        pause();
    endtask : start

    // Data rises while the clock line is high
    task automatic stop();
        sda_oe <= 1'b1;
        pause();
        scl_oe <= 1'b0;
        pause();
        sda_oe <= 1'b0;
        pause();
    endtask : stop

    // One bit; data only moves while the clock line is low
    task automatic bit_io(input logic b, output logic r);
        sda_oe <= ~b;
        pause();
        scl_oe <= 1'b0;
        pause();
        r = sda_wire;
        scl_oe <= 1'b1;
        pause();
    endtask : bit_io

    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : scb_host_model

// File: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic                       clk;
    logic                       reset;
    logic                       link_clk;
    logic [3:0]                 strap;
    logic                       host_scl_oe;
    logic                       host_sda_oe;
    logic                       scl_wire;
    logic                       sda_wire;
    scb_pkg::scb_pin_drive_type scl_drive;
    scb_pkg::scb_pin_drive_type sda_drive;
    logic [6:0]                 active_addr;
    logic                       src_sel;
    logic [6:0]                 own;
    int                         num_errors;
    int                         cmp_count;

    // Pull-ups; any enabled driver wins low
    assign scl_wire = ~(host_scl_oe | scl_drive.oe);
    assign sda_wire = ~(host_sda_oe | sda_drive.oe);

    // System clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Link clock, unrelated phase
    initial begin
        link_clk = 1'b0;
        #17;
        forever #62.5 link_clk = ~link_clk;
    end

    scb_target scb_target_i (
        .clk                   (clk),
        .reset                 (reset),
        .link_clk              (link_clk),
        .scl_in                (scl_wire),
        .sda_in                (sda_wire),
        .address_strap_pin     (strap),
        .scl_drive             (scl_drive),
        .sda_drive             (sda_drive),
        .active_target_address (active_addr),
        .address_source_select (src_sel)
    );

    scb_host_model scb_host_model_i (
        .clk      (clk),
        .sda_wire (sda_wire),
        .scl_oe   (host_scl_oe),
        .sda_oe   (host_sda_oe)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic settle();
        repeat (40) @(posedge clk);
    endtask : settle

    // Byte sent by the host, acknowledge level compared
    task automatic send(input logic [7:0] d, input logic lvl);
        logic [7:0] q;
        logic       ack;
        scb_host_model_i.xfer(d, 1'b1, q, ack);
        check({7'h00, ack}, {7'h00, lvl}, "ack level");
    endtask : send

    // Byte read by the host with its own acknowledge
    task automatic fetch(input logic ack_in, input logic [7:0] exp);
        logic [7:0] q;
        logic       ack;
        scb_host_model_i.xfer(8'hFF, ack_in, q, ack);
        check(q, exp, "read data");
    endtask : fetch

    task automatic probe(input logic [6:0] a, input logic lvl);
        scb_host_model_i.start();
        send({a, 1'b0}, lvl);
        scb_host_model_i.stop();
    endtask : probe

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] off,
                          input logic [7:0] d, input logic lvl);
        scb_host_model_i.start();
        send({a, 1'b0}, lvl);
        send(off, lvl);
        send(d, lvl);
        scb_host_model_i.stop();
    endtask : wr_reg

    // Offset set, repeated start, same byte twice then host refusal
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] off,
                          input logic [7:0] exp);
        scb_host_model_i.start();
        send({a, 1'b0}, 1'b0);
        send(off, 1'b0);
        scb_host_model_i.start();
        send({a, 1'b1}, 1'b0);
        fetch(1'b0, exp);
        fetch(1'b1, exp);
        scb_host_model_i.stop();
    endtask : rd_reg

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Device never drives the clock line nor drives high
    always @(posedge clk) begin
        if (!reset) begin
            if ({scl_drive, sda_drive.out} !== 3'h0) begin
                num_errors++;
                $display("Error at %0t: line driven high", $time);
            end
        end
    end

    // Watchdog
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        reset = 1'b1;
        strap = 4'h0;
        num_errors = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        settle();
        check({7'h00, src_sel}, 8'h00, "source after reset");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            strap <= i[3:0];
            own = 7'h0C + 7'(i);
            settle();
            check({1'b0, active_addr}, {1'b0, own}, "strap address");
            probe(own, 1'b0);
            probe(own + 7'h01, 1'b1);
        end
        $display("strap test done");
        rd_reg(own, 8'h00, 8'h00);
        wr_reg(own, 8'h05, 8'hA5, 1'b0);
        rd_reg(own, 8'h05, 8'hA5);
        wr_reg(7'h30, 8'h05, 8'h3C, 1'b1);
        rd_reg(own, 8'h05, 8'hA5);
        $display("data test done");
        scb_host_model_i.start();
        send({own, 1'b0}, 1'b0);
        send(8'h05, 1'b0);
        scb_host_model_i.stop();
        send(8'h11, 1'b1);
        rd_reg(own, 8'h05, 8'hA5);
        $display("stop test done");
        wr_reg(own, 8'h00, 8'h67, 1'b0);
        settle();
        check({1'b0, active_addr}, 8'h33, "programmed address");
        check({7'h00, src_sel}, 8'h01, "source select");
        probe(7'h33, 1'b0);
        probe(own, 1'b1);
        rd_reg(7'h33, 8'h00, 8'h67);
        wr_reg(7'h33, 8'h00, 8'h66, 1'b0);
        settle();
        check({7'h00, src_sel}, 8'h00, "strap source back");
        probe(own, 1'b0);
        probe(7'h33, 1'b1);
        $display("override test done");
        results();
    end
endmodule : tb_top

// File: verilog/scb_reg_mem.sv
`timescale 1ns/1ps

module scb_reg_mem #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Write port and registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : scb_reg_mem

// File: verilog/scb_target.sv
// Behaviour
// [R1] Sixteen selectable target addresses share one bus
// [R2] Strap index maps to addresses 0x0C..0x1B
// [R3] Detect START as transaction beginning
// [R4] STOP while SCL high returns to idle
// [R5] Master opens with START, closes with STOP
// [R6] ACK own address, NACK any other
// [R7] Acknowledge every received write data byte
// [R8] Master ACKs wanted bytes, NACKs last
// [R9] Lines only driven low, never high
// [R10] Programmed address held in offset 0 bits 7:1
// [R11] Offset 0 bit 0 selects programmed address
// [R12] First write byte sets offset; data follows
`timescale 1ns/1ps

module scb_target (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       link_clk,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    input  wire logic [3:0]                 address_strap_pin,
    output scb_pkg::scb_pin_drive_type      scl_drive,
    output scb_pkg::scb_pin_drive_type      sda_drive,
    output logic      [6:0]                 active_target_address,
    output logic                            address_source_select
);

    scb_pkg::scb_link_state_type l_reg, l_next, l_rst;
    scb_pkg::scb_sys_state_type  s_reg, s_next;
    logic [7:0] mem_rdata;
    logic [7:0] rd_value;
    logic       scl_rise, scl_fall, start_ev, stop_ev, link_rst;

    // Strap index 0..15 onto consecutive addresses
    function automatic logic [6:0] strap_to_addr(input logic [3:0] idx);
        strap_to_addr = scb_pkg::SCB_STRAP_BASE_ADDR + {3'h0, idx}; // [R1] [R2]
    endfunction : strap_to_addr

    scb_reg_mem #(
        .DEPTH (scb_pkg::SCB_REG_DEPTH),
        .WIDTH (8)
    ) u_mem (
        .clk   (link_clk),
        .we    (l_reg.wr_en),
        .waddr (l_reg.offset),
        .wdata (l_reg.wr_data),
        .raddr (l_reg.offset),
        .rdata (mem_rdata)
    );

    // Bus events from synchronised pins
    assign link_rst = l_reg.rst_s2;
    assign scl_rise = l_reg.scl_s2 & ~l_reg.scl_prev;
    assign scl_fall = ~l_reg.scl_s2 & l_reg.scl_prev;
    assign start_ev = l_reg.scl_s2 & l_reg.scl_prev
                      & ~l_reg.sda_s2 & l_reg.sda_prev; // [R3]
    assign stop_ev  = l_reg.scl_s2 & l_reg.scl_prev
                      & l_reg.sda_s2 & ~l_reg.sda_prev; // [R4]
    assign rd_value = (l_reg.offset == scb_pkg::SCB_TARGET_ADDR_OFFSET)
                      ? l_reg.target_reg : mem_rdata; // [R12]

    // Reset image of the link state
    always_comb begin
        l_rst            = '0;
        l_rst.scl_s1     = 1'b1;
        l_rst.scl_s2     = 1'b1;
        l_rst.scl_prev   = 1'b1;
        l_rst.sda_s1     = 1'b1;
        l_rst.sda_s2     = 1'b1;
        l_rst.sda_prev   = 1'b1;
        l_rst.state      = scb_pkg::SCB_IDLE;
        l_rst.target_reg = scb_pkg::SCB_TARGET_ADDR_RESET;
    end

    // Link-side protocol engine
    always_comb begin
        l_next          = l_reg;
        l_next.rst_s1   = reset;
        l_next.rst_s2   = l_reg.rst_s1;
        l_next.scl_s1   = scl_in;
        l_next.scl_s2   = l_reg.scl_s1;
        l_next.scl_prev = l_reg.scl_s2;
        l_next.sda_s1   = sda_in;
        l_next.sda_s2   = l_reg.sda_s1;
        l_next.sda_prev = l_reg.sda_s2;
        l_next.strap_s1 = address_strap_pin;
        l_next.strap_s2 = l_reg.strap_s1;
        l_next.wr_en    = 1'b0;
        l_next.sda_drv.out = 1'b0; // [R9]
        l_next.scl_drv     = '0;   // [R9]
        // Address source choice
        l_next.ovr = l_reg.target_reg[scb_pkg::SCB_SOURCE_SEL_BIT]; // [R11]
        l_next.own_addr = l_next.ovr
            ? l_reg.target_reg[scb_pkg::SCB_ADDR_MSB:scb_pkg::SCB_ADDR_LSB]
            : strap_to_addr(l_reg.strap_s2); // [R10] [R11]
        if ({l_next.ovr, l_next.own_addr} != {l_reg.ovr, l_reg.own_addr}) begin
            l_next.addr_tgl = ~l_reg.addr_tgl;
        end
        if (start_ev) begin
            l_next.state      = scb_pkg::SCB_ADDR; // [R3]
            l_next.cnt        = 4'h0;
            l_next.sda_drv.oe = 1'b0;
        end else if (stop_ev) begin
            l_next.state      = scb_pkg::SCB_IDLE; // [R4]
            l_next.sda_drv.oe = 1'b0;
        end else begin
            case (l_reg.state)
                scb_pkg::SCB_ADDR: begin
                    if (scl_rise) begin
                        l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
                        l_next.cnt   = l_reg.cnt + 4'h1;
                    end else if (scl_fall &&
                                 l_reg.cnt == scb_pkg::SCB_BYTE_BITS) begin
                        if (l_reg.shift[7:1] == l_reg.own_addr) begin
                            l_next.sda_drv.oe = 1'b1; // [R6]
                            l_next.rw         = l_reg.shift[0];
                            l_next.state      = scb_pkg::SCB_AACK;
                        end else begin
                            l_next.state = scb_pkg::SCB_IDLE; // [R6]
                        end
                    end
                end
                scb_pkg::SCB_AACK: begin
                    if (scl_fall && l_reg.rw) begin
                        l_next.shift      = rd_value;
                        l_next.sda_drv.oe = ~rd_value[7];
                        l_next.cnt        = 4'h1;
                        l_next.state      = scb_pkg::SCB_RDATA;
                    end else if (scl_fall) begin
                        l_next.sda_drv.oe = 1'b0;
                        l_next.first      = 1'b1;
                        l_next.cnt        = 4'h0;
                        l_next.state      = scb_pkg::SCB_WDATA;
                    end
                end
                scb_pkg::SCB_WDATA: begin
                    if (scl_rise) begin
                        l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
                        l_next.cnt   = l_reg.cnt + 4'h1;
                    end else if (scl_fall &&
                                 l_reg.cnt == scb_pkg::SCB_BYTE_BITS) begin
                        l_next.sda_drv.oe = 1'b1; // [R7]
                        l_next.state      = scb_pkg::SCB_WACK;
                        if (l_reg.first) begin
                            l_next.offset = l_reg.shift; // [R12]
                        end else if (l_reg.offset ==
                                     scb_pkg::SCB_TARGET_ADDR_OFFSET) begin
                            l_next.target_reg = l_reg.shift; // [R10]
                        end else begin
                            l_next.wr_en   = 1'b1; // [R12]
                            l_next.wr_data = l_reg.shift;
                        end
                    end
                end
                scb_pkg::SCB_WACK: begin
                    if (scl_fall) begin
                        l_next.sda_drv.oe = 1'b0;
                        l_next.cnt        = 4'h0;
                        l_next.first      = 1'b0;
                        l_next.state      = scb_pkg::SCB_WDATA;
                    end
                end
                scb_pkg::SCB_RDATA: begin
                    if (scl_fall &&
                        l_reg.cnt == scb_pkg::SCB_BYTE_BITS) begin
                        l_next.sda_drv.oe = 1'b0;
                        l_next.state      = scb_pkg::SCB_RACK;
                    end else if (scl_fall) begin
                        l_next.sda_drv.oe = ~l_reg.shift[6];
                        l_next.shift      = {l_reg.shift[6:0], 1'b0};
                        l_next.cnt        = l_reg.cnt + 4'h1;
                    end
                end
                scb_pkg::SCB_RACK: begin
                    if (scl_rise) begin
                        l_next.mnack = l_reg.sda_s2;
                    end else if (scl_fall && l_reg.mnack) begin
                        l_next.state = scb_pkg::SCB_IDLE; // [R8]
                    end else if (scl_fall) begin
                        l_next.shift      = rd_value; // [R8]
                        l_next.sda_drv.oe = ~rd_value[7];
                        l_next.cnt        = 4'h1;
                        l_next.state      = scb_pkg::SCB_RDATA;
                    end
                end
                default: begin
                    l_next.state = scb_pkg::SCB_IDLE; // [R5]
                end
            endcase
        end
        // Reset keeps only the reset synchroniser running
        if (link_rst) begin
            l_next        = l_rst;
            l_next.rst_s1 = reset;
            l_next.rst_s2 = l_reg.rst_s1;
        end
    end

    // Link-domain register
    always_ff @(posedge link_clk) begin
        l_reg <= l_next;
    end

    // System side: toggle handshake captures the active address
    always_comb begin
        s_next          = s_reg;
        s_next.tgl_s1   = l_reg.addr_tgl;
        s_next.tgl_s2   = s_reg.tgl_s1;
        s_next.tgl_prev = s_reg.tgl_s2;
        if (s_reg.tgl_s2 != s_reg.tgl_prev) begin
            s_next.active_addr = l_reg.own_addr;
            s_next.override    = l_reg.ovr;
        end
        if (reset) begin
            s_next = '0;
        end
    end

    // System-domain register
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign scl_drive             = l_reg.scl_drv;
    assign sda_drive             = l_reg.sda_drv;
    assign active_target_address = s_reg.active_addr;
    assign address_source_select = s_reg.override;

    // Checks on the link engine
    start_addr_a: assert property (@(posedge link_clk) disable iff (link_rst) // [R3]
        start_ev |=> l_reg.state == scb_pkg::SCB_ADDR && !l_reg.sda_drv.oe)
        else $error("start not followed by address phase");
    stop_idle_a: assert property (@(posedge link_clk) disable iff (link_rst) // [R4]
        stop_ev && !start_ev |=> l_reg.state == scb_pkg::SCB_IDLE
                                 && !l_reg.sda_drv.oe)
        else $error("stop did not return to idle");
    ack_match_a: assert property (@(posedge link_clk) disable iff (link_rst) // [R6]
        l_reg.state == scb_pkg::SCB_ADDR && scl_fall && !start_ev && !stop_ev
        && l_reg.cnt == 4'h8 && l_reg.shift[7:1] == l_reg.own_addr
        |=> l_reg.sda_drv.oe && l_reg.state == scb_pkg::SCB_AACK)
        else $error("own address not acknowledged");
    nack_miss_a: assert property (@(posedge link_clk) disable iff (link_rst) // [R6]
        l_reg.state == scb_pkg::SCB_ADDR && scl_fall && !start_ev && !stop_ev
        && l_reg.cnt == 4'h8 && l_reg.shift[7:1] != l_reg.own_addr
        |=> !l_reg.sda_drv.oe [*2])
        else $error("foreign address acknowledged");
    write_ack_a: assert property (@(posedge link_clk) disable iff (link_rst) // [R7]
        l_reg.state == scb_pkg::SCB_WDATA && scl_fall && !start_ev
        && !stop_ev && l_reg.cnt == 4'h8
        |=> l_reg.sda_drv.oe && l_reg.state == scb_pkg::SCB_WACK)
        else $error("write byte not acknowledged");
    low_only_a: assert property (@(posedge link_clk) disable iff (reset || link_rst) // [R9]
        !l_reg.sda_drv.out && !l_reg.scl_drv.oe && !l_reg.scl_drv.out)
        else $error("line driven high or clock driven");
    reg_write_a: assert property (@(posedge link_clk) disable iff (link_rst) // [R10]
        l_reg.state == scb_pkg::SCB_WDATA && scl_fall && !start_ev
        && !stop_ev && l_reg.cnt == 4'h8 && !l_reg.first
        && l_reg.offset == 8'h00
        |=> l_reg.target_reg == $past(l_reg.shift))
        else $error("offset zero write lost");
    // Own address follows the previous cycle's register and strap
    addr_source_a: assert property (@(posedge link_clk) disable iff (reset || link_rst) // [R11]
        1'b1 |=> l_reg.own_addr == ($past(l_reg.target_reg[0])
                               ? $past(l_reg.target_reg[7:1])
                               : scb_pkg::SCB_STRAP_BASE_ADDR
                                 + {3'h0, $past(l_reg.strap_s2)}))
        else $error("wrong own address source");

    read_done_c: cover property (@(posedge link_clk) disable iff (link_rst)
        l_reg.state == scb_pkg::SCB_RACK ##1 l_reg.state == scb_pkg::SCB_IDLE);
    write_done_c: cover property (@(posedge link_clk) disable iff (link_rst)
        l_reg.wr_en);
    foreign_c: cover property (@(posedge link_clk) disable iff (link_rst)
        l_reg.state == scb_pkg::SCB_ADDR ##1 l_reg.state == scb_pkg::SCB_IDLE);

endmodule : scb_target
